// ==== core/fpc_pkg.sv ====
// shared constants and types for the front panel control block
package fpc_pkg;
   // source formats
   typedef enum logic [1:0] {
      SRC_CPST,
      SRC_YC,
      SRC_BETA,
      SRC_SMPTE
   } fpc_src_t;

   // editor sections
   typedef enum logic [1:0] {
      SEC_IDLE,
      SEC_SOURCE,
      SEC_GAIN
   } fpc_sec_t;

   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned BLINK_TIME_S  = 15;
   localparam int unsigned COMMIT_CYC    = BLINK_TIME_S * CLK_HZ;
   localparam int unsigned DEBOUNCE_MS   = 10;
   localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_MS * CLK_HZ) / 1000;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned BLINK_HALF_CYC = (BLINK_HALF_MS * CLK_HZ) / 1000;

   // gain in percent, one step per press
   localparam logic [7:0] GAIN_MIN  = 8'h32;
   localparam logic [7:0] GAIN_NOM  = 8'h64;
   localparam logic [7:0] GAIN_MAX  = 8'h96;
   localparam logic [7:0] GAIN_STEP = 8'h01;

   localparam logic [1:0] SRC_RST   = 2'h0;
   localparam int unsigned CNT_W    = 28;
endpackage

// ==== core/fpc_btn_if.sv ====
// carries debounced button events from the button filter to the editor
`timescale 1ns/1ns
`default_nettype none
interface fpc_btn_if;
   logic sec_press;
   logic right_press;
   logic left_press;
   logic both_press;

   modport src (
      output sec_press,
      output right_press,
      output left_press,
      output both_press
   );
   modport dst (
      input sec_press,
      input right_press,
      input left_press,
      input both_press
   );
endinterface
`default_nettype wire

// ==== core/fpc_btn_filter.sv ====
// button synchroniser, debouncer and edge detector, section and chord on press, single arrows on release
`timescale 1ns/1ns
`default_nettype none
module fpc_btn_filter #(
   parameter int unsigned DEB_CYC = fpc_pkg::DEBOUNCE_CYC
) (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  wire logic   sec_btn_i,
   input  wire logic   right_btn_i,
   input  wire logic   left_btn_i,
   fpc_btn_if.src      ev
);
   logic [2:0]  raw;
   logic [2:0]  s1_ff;
   logic [2:0]  s2_ff;
   logic [2:0]  stab_ff;
   logic [2:0]  nxt_stab;
   logic [17:0] cnt_ff [3];
   logic [17:0] nxt_cnt [3];
   logic [2:0]  rise;
   logic        arrow_held_ff;
   logic        nxt_arrow_held;
   logic        sec_ev_ff;
   logic        right_ev_ff;
   logic        left_ev_ff;
   logic        both_ev_ff;
   logic        nxt_sec_ev;
   logic        nxt_right_ev;
   logic        nxt_left_ev;
   logic        nxt_both_ev;

   assign raw = {left_btn_i, right_btn_i, sec_btn_i};

   // two-stage synchroniser, first stage read only by second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_ff <= 3'h0;
         s2_ff <= 3'h0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_deb
         always_comb begin
            nxt_cnt[g]  = cnt_ff[g];
            nxt_stab[g] = stab_ff[g];
            if (s2_ff[g] == stab_ff[g]) begin
               nxt_cnt[g] = 18'h0;
            end else if (cnt_ff[g] >= 18'(DEB_CYC - 1)) begin
               nxt_cnt[g]  = 18'h0;
               nxt_stab[g] = s2_ff[g];
            end else begin
               nxt_cnt[g] = cnt_ff[g] + 18'h1;
            end
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_ff[g]  <= 18'h0;
               stab_ff[g] <= 1'b0;
            end else begin
               cnt_ff[g]  <= nxt_cnt[g];
               stab_ff[g] <= nxt_stab[g];
            end
         end
      end
   endgenerate

   assign rise = nxt_stab & ~stab_ff;

   // one event per press; chord suppresses singles
   always_comb begin
      nxt_sec_ev     = rise[0];
      nxt_right_ev   = 1'b0;
      nxt_left_ev    = 1'b0;
      nxt_both_ev    = 1'b0;
      nxt_arrow_held = arrow_held_ff;
      if (nxt_stab[1] && nxt_stab[2] && (rise[1] || rise[2]) && !arrow_held_ff) begin
         nxt_both_ev    = 1'b1;
         nxt_arrow_held = 1'b1;
      end else if (!arrow_held_ff) begin
         // single arrow steps on release, so a chord is never a step
         nxt_right_ev = !nxt_stab[1] && stab_ff[1] && !nxt_stab[2];
         nxt_left_ev  = !nxt_stab[2] && stab_ff[2] && !nxt_stab[1];
      end
      if (!nxt_stab[1] && !nxt_stab[2]) begin
         nxt_arrow_held = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arrow_held_ff <= 1'b0;
         sec_ev_ff     <= 1'b0;
         right_ev_ff   <= 1'b0;
         left_ev_ff    <= 1'b0;
         both_ev_ff    <= 1'b0;
      end else begin
         arrow_held_ff <= nxt_arrow_held;
         sec_ev_ff     <= nxt_sec_ev;
         right_ev_ff   <= nxt_right_ev;
         left_ev_ff    <= nxt_left_ev;
         both_ev_ff    <= nxt_both_ev;
      end
   end

   assign ev.sec_press   = sec_ev_ff;
   assign ev.right_press = right_ev_ff;
   assign ev.left_press  = left_ev_ff;
   assign ev.both_press  = both_ev_ff;

   AST_CHORD_NO_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      both_ev_ff |-> !right_ev_ff && !left_ev_ff)
      else $error("chord also produced a step");
endmodule
`default_nettype wire

// ==== core/fpc_top.sv ====
// front panel editor, gain and source settings, lamps and commit timer
`timescale 1ns/1ns
`default_nettype none
// Contract
// - section button enables editing, then cycles through sections with wrap
// - arrows step the selection or raise and lower the selected value
// - edited lamp blinks for fifteen seconds, then value goes to storage; the logic blinks the shown section's lamp instead
// - power loss before timeout stores nothing; stored value returns at power-up
// - source is one of four formats; only its lamp lights green
// - in gain section right raises gain, left lowers it
// - gain lamp green at nominal, red otherwise
// - in gain section both arrows together reset gain to nominal
// - input lamp green only when selected format input is detected
// - input lamp dark while an internal test pattern is the source
// - power lamp green only while power good input is high
// - host-only settings are neither shown nor changed from the panel
// - gain limited between fifty and one hundred fifty percent
module fpc_top #(
   parameter int unsigned COMMIT_CYC = fpc_pkg::COMMIT_CYC,
   parameter int unsigned DEB_CYC    = fpc_pkg::DEBOUNCE_CYC,
   parameter int unsigned BLINK_CYC  = fpc_pkg::BLINK_HALF_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       sec_btn_i,
   input  wire logic       right_btn_i,
   input  wire logic       left_btn_i,
   input  wire logic       sig_detect_i,
   input  wire logic       test_pat_i,
   input  wire logic       pwr_good_i,
   input  wire logic       nv_valid_i,
   input  wire logic [1:0] nv_src_i,
   input  wire logic [7:0] nv_gain_i,
   output logic [1:0]      src_sel_o,
   output logic [7:0]      gain_o,
   output logic [3:0]      src_lamp_o,
   output logic            gain_green_o,
   output logic            gain_red_o,
   output logic            in_lamp_o,
   output logic            pwr_lamp_o,
   output logic            editing_o,
   output logic            nv_wr_o,
   output logic [1:0]      nv_wr_src_o,
   output logic [7:0]      nv_wr_gain_o
);
   fpc_btn_if btn ();

   fpc_btn_filter #(
      .DEB_CYC (DEB_CYC)
   ) u_filt (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .sec_btn_i   (sec_btn_i),
      .right_btn_i (right_btn_i),
      .left_btn_i  (left_btn_i),
      .ev          (btn.src)
   );

   // status pins come from outside the clock domain
   logic [3:0] st1_ff;
   logic [3:0] st2_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st1_ff <= 4'h0;
         st2_ff <= 4'h0;
      end else begin
         st1_ff <= {nv_valid_i, pwr_good_i, test_pat_i, sig_detect_i};
         st2_ff <= st1_ff;
      end
   end
   logic det_s;
   logic tpat_s;
   logic pgood_s;
   logic nvv_s;
   assign det_s   = st2_ff[0];
   assign tpat_s  = st2_ff[1];
   assign pgood_s = st2_ff[2];
   assign nvv_s   = st2_ff[3];

   fpc_pkg::fpc_sec_t sec_ff;
   fpc_pkg::fpc_sec_t nxt_sec;
   logic [1:0]  src_ff;
   logic [1:0]  nxt_src;
   logic [7:0]  gain_ff;
   logic [7:0]  nxt_gain;
   logic        loaded_ff;
   logic        nxt_loaded;
   logic        pend_ff;
   logic        nxt_pend;
   logic [27:0] tmo_ff;
   logic [27:0] nxt_tmo;
   logic        nv_wr_ff;
   logic        nxt_nv_wr;
   logic [1:0]  nv_src_ff;
   logic [1:0]  nxt_nv_src;
   logic [7:0]  nv_gain_ff;
   logic [7:0]  nxt_nv_gain;
   logic        edit_ev;

   // editor: sections, steps, gain clamp, commit timer
   always_comb begin
      nxt_sec     = sec_ff;
      nxt_src     = src_ff;
      nxt_gain    = gain_ff;
      nxt_loaded  = loaded_ff;
      nxt_pend    = pend_ff;
      nxt_tmo     = tmo_ff;
      nxt_nv_wr   = 1'b0;
      nxt_nv_src  = nv_src_ff;
      nxt_nv_gain = nv_gain_ff;
      edit_ev     = 1'b0;
      // restore last stored values once after power-up
      if (!loaded_ff && nvv_s) begin
         nxt_loaded = 1'b1;
         nxt_src    = nv_src_i;
         if (nv_gain_i >= fpc_pkg::GAIN_MIN && nv_gain_i <= fpc_pkg::GAIN_MAX) begin
            nxt_gain = nv_gain_i;
         end
      end
      // section button enables and cycles with wrap
      if (btn.sec_press) begin
         unique case (sec_ff)
            fpc_pkg::SEC_IDLE:   nxt_sec = fpc_pkg::SEC_SOURCE;
            fpc_pkg::SEC_SOURCE: nxt_sec = fpc_pkg::SEC_GAIN;
            fpc_pkg::SEC_GAIN:   nxt_sec = fpc_pkg::SEC_SOURCE;
            default:             nxt_sec = fpc_pkg::SEC_IDLE;
         endcase
      end else if (sec_ff == fpc_pkg::SEC_SOURCE) begin
         if (btn.right_press) begin
            nxt_src = src_ff + 2'h1;
            edit_ev = 1'b1;
         end else if (btn.left_press) begin
            nxt_src = src_ff - 2'h1;
            edit_ev = 1'b1;
         end
      end else if (sec_ff == fpc_pkg::SEC_GAIN) begin
         if (btn.both_press) begin
            nxt_gain = fpc_pkg::GAIN_NOM;
            edit_ev  = 1'b1;
         end else if (btn.right_press) begin
            if (gain_ff < fpc_pkg::GAIN_MAX) begin
               nxt_gain = gain_ff + fpc_pkg::GAIN_STEP;
            end
            edit_ev = 1'b1;
         end else if (btn.left_press) begin
            if (gain_ff > fpc_pkg::GAIN_MIN) begin
               nxt_gain = gain_ff - fpc_pkg::GAIN_STEP;
            end
            edit_ev = 1'b1;
         end
      end
      // a new edit restarts the timeout
      if (edit_ev) begin
         nxt_pend = 1'b1;
         nxt_tmo  = 28'h0;
      // commit when the timeout runs out
      end else if (pend_ff) begin
         if (tmo_ff >= 28'(COMMIT_CYC - 1)) begin
            nxt_pend    = 1'b0;
            nxt_tmo     = 28'h0;
            nxt_nv_wr   = 1'b1;
            nxt_nv_src  = src_ff;
            nxt_nv_gain = gain_ff;
            nxt_sec     = btn.sec_press ? nxt_sec : fpc_pkg::SEC_IDLE; // same-cycle press counts
         end else begin
            nxt_tmo = tmo_ff + 28'h1;
         end
      end
   end

   // reset drops any pending edit, nothing is written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_ff     <= fpc_pkg::SEC_IDLE;
         src_ff     <= fpc_pkg::SRC_RST;
         gain_ff    <= fpc_pkg::GAIN_NOM;
         loaded_ff  <= 1'b0;
         pend_ff    <= 1'b0;
         tmo_ff     <= 28'h0;
         nv_wr_ff   <= 1'b0;
         nv_src_ff  <= fpc_pkg::SRC_RST;
         nv_gain_ff <= fpc_pkg::GAIN_NOM;
      end else begin
         sec_ff     <= nxt_sec;
         src_ff     <= nxt_src;
         gain_ff    <= nxt_gain;
         loaded_ff  <= nxt_loaded;
         pend_ff    <= nxt_pend;
         tmo_ff     <= nxt_tmo;
         nv_wr_ff   <= nxt_nv_wr;
         nv_src_ff  <= nxt_nv_src;
         nv_gain_ff <= nxt_nv_gain;
      end
   end

   // blink phase divider for the edited lamp
   logic [23:0] bl_cnt_ff;
   logic [23:0] nxt_bl_cnt;
   logic        bl_ph_ff;
   logic        nxt_bl_ph;
   always_comb begin
      nxt_bl_cnt = bl_cnt_ff + 24'h1;
      nxt_bl_ph  = bl_ph_ff;
      if (!pend_ff) begin
         nxt_bl_cnt = 24'h0;
         nxt_bl_ph  = 1'b1;
      end else if (bl_cnt_ff >= 24'(BLINK_CYC - 1)) begin
         nxt_bl_cnt = 24'h0;
         nxt_bl_ph  = !bl_ph_ff;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bl_cnt_ff <= 24'h0;
         bl_ph_ff  <= 1'b1;
      end else begin
         bl_cnt_ff <= nxt_bl_cnt;
         bl_ph_ff  <= nxt_bl_ph;
      end
   end

   // lamps, all registered
   logic [3:0] nxt_src_lamp;
   logic       nxt_gg;
   logic       nxt_gr;
   logic       gain_lit;
   logic       src_lit;
   always_comb begin
      src_lit  = !(pend_ff && sec_ff == fpc_pkg::SEC_SOURCE) || bl_ph_ff;
      gain_lit = !(pend_ff && sec_ff == fpc_pkg::SEC_GAIN) || bl_ph_ff;
      // one-hot source lamp, blinks while pending in the source section
      nxt_src_lamp = src_lit ? (4'h1 << nxt_src) : 4'h0;
      // green at nominal, red off nominal
      nxt_gg = gain_lit && (nxt_gain == fpc_pkg::GAIN_NOM);
      nxt_gr = gain_lit && (nxt_gain != fpc_pkg::GAIN_NOM);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_lamp_o   <= 4'h0;
         gain_green_o <= 1'b0;
         gain_red_o   <= 1'b0;
         in_lamp_o    <= 1'b0;
         pwr_lamp_o   <= 1'b0;
         editing_o    <= 1'b0;
         src_sel_o    <= fpc_pkg::SRC_RST;
         gain_o       <= fpc_pkg::GAIN_NOM;
         nv_wr_o      <= 1'b0;
         nv_wr_src_o  <= fpc_pkg::SRC_RST;
         nv_wr_gain_o <= fpc_pkg::GAIN_NOM;
      end else begin
         src_lamp_o   <= nxt_src_lamp;
         gain_green_o <= nxt_gg;
         gain_red_o   <= nxt_gr;
         // detect of selected format; dark on test pattern
         in_lamp_o    <= det_s && !tpat_s;
         pwr_lamp_o   <= pgood_s;
         editing_o    <= (nxt_sec != fpc_pkg::SEC_IDLE);
         src_sel_o    <= nxt_src;
         gain_o       <= nxt_gain;
         nv_wr_o      <= nxt_nv_wr;
         nv_wr_src_o  <= nxt_nv_src;
         nv_wr_gain_o <= nxt_nv_gain;
      end
   end

   AST_GAIN_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      gain_ff >= fpc_pkg::GAIN_MIN && gain_ff <= fpc_pkg::GAIN_MAX)
      else $error("gain out of range");
   AST_CHORD_NOM: assert property (@(posedge clk_i) disable iff (rst_i)
      btn.both_press && sec_ff == fpc_pkg::SEC_GAIN && !btn.sec_press
      |=> gain_ff == fpc_pkg::GAIN_NOM)
      else $error("chord did not restore nominal gain");
   AST_GAIN_UP: assert property (@(posedge clk_i) disable iff (rst_i)
      btn.right_press && !btn.sec_press && sec_ff == fpc_pkg::SEC_GAIN
      && gain_ff < fpc_pkg::GAIN_MAX && !(!loaded_ff && nvv_s)
      |=> gain_ff == $past(gain_ff) + fpc_pkg::GAIN_STEP)
      else $error("right arrow did not raise gain");
   AST_SEC_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      btn.sec_press && sec_ff == fpc_pkg::SEC_GAIN |=> sec_ff == fpc_pkg::SEC_SOURCE)
      else $error("section did not wrap");
   AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
      edit_ev |=> pend_ff && tmo_ff == 28'h0 && !nv_wr_ff)
      else $error("edit did not restart timeout");
   AST_COMMIT: assert property (@(posedge clk_i) disable iff (rst_i)
      nv_wr_ff |-> $past(pend_ff) && nv_gain_ff == $past(gain_ff))
      else $error("commit without expiring timeout");
   AST_IN_LAMP: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(tpat_s) |-> !in_lamp_o)
      else $error("input lamp lit on test pattern");
   AST_SRC_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot0(src_lamp_o) && (src_lamp_o == 4'h0 || src_lamp_o[src_sel_o]))
      else $error("source lamp not the selected one");
   AST_GAIN_LAMP: assert property (@(posedge clk_i) disable iff (rst_i)
      !(gain_green_o && gain_red_o) && (gain_green_o -> gain_o == fpc_pkg::GAIN_NOM))
      else $error("gain lamp colour wrong");
endmodule
`default_nettype wire

// ==== testbench/fpc_op_model.sv ====
// operator at the buttons plus the nonvolatile store behind the panel
`timescale 1ns/1ns
`default_nettype none
module fpc_op_model #(
   parameter logic [1:0]  INIT_SRC  = 2'h2,
   parameter logic [7:0]  INIT_GAIN = 8'h5A,
   parameter int unsigned HOLD_CYC  = 12
) (
   input  wire logic       clk_i,
   input  wire logic       nv_wr_i,
   input  wire logic [1:0] nv_wr_src_i,
   input  wire logic [7:0] nv_wr_gain_i,
   output logic            sec_btn_o,
   output logic            right_btn_o,
   output logic            left_btn_o,
   output logic            nv_valid_o,
   output logic [1:0]      nv_src_o,
   output logic [7:0]      nv_gain_o
);
   // buttons idle released, store holds its power-up contents
   initial begin
      sec_btn_o   = 1'b0;
      right_btn_o = 1'b0;
      left_btn_o  = 1'b0;
      nv_valid_o  = 1'b0;
      nv_src_o    = INIT_SRC;
      nv_gain_o   = INIT_GAIN;
   end

   // store survives reset
   // only a commit pulse changes the contents, a device reset never does
   always @(posedge clk_i) begin
      if (nv_wr_i === 1'b1) begin
         nv_src_o  <= nv_wr_src_i;
         nv_gain_o <= nv_wr_gain_i;
      end
   end

   // contents become readable some time after power-up
   task automatic store_ready();
      @(posedge clk_i);
      nv_valid_o <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask

   // one press: 0 section, 1 right, 2 left, 3 both arrows together
   // hold and gap well above sync plus debounce so no press is lost
   task automatic press(input int unsigned k);
      @(posedge clk_i);
      case (k)
         0: sec_btn_o <= 1'b1;
         1: right_btn_o <= 1'b1;
         2: left_btn_o <= 1'b1;
         default: begin
            right_btn_o <= 1'b1;
            left_btn_o  <= 1'b1;
         end
      endcase
      repeat (HOLD_CYC) @(posedge clk_i);
      sec_btn_o   <= 1'b0;
      right_btn_o <= 1'b0;
      left_btn_o  <= 1'b0;
      repeat (HOLD_CYC) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking testbench for the front panel control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
   localparam int unsigned COMMIT = 200;
   localparam int unsigned LIMIT  = 9000;
   localparam int unsigned BLINK  = 8;
   logic       clk_i        = 1'b0;
   logic       rst_i;
   logic       sig_detect_i;
   logic       test_pat_i;
   logic       pwr_good_i;
   logic       sec_b, right_b, left_b, nv_valid, nv_wr, gain_green, gain_red;
   logic       in_lamp, pwr_lamp, editing;
   logic [1:0] nv_src, src_sel, nv_wr_src;
   logic [7:0] nv_gain, gain, nv_wr_gain;
   logic [3:0] src_lamp;
   int         miscompares = 0;
   int         n_checks    = 0;
   int         cyc         = 0;
   int         nwr         = 0;
   int         wt;

   fpc_top #(.COMMIT_CYC(COMMIT), .DEB_CYC(4), .BLINK_CYC(BLINK)) i_fpc_top (
      .clk_i(clk_i), .rst_i(rst_i), .sec_btn_i(sec_b), .right_btn_i(right_b),
      .left_btn_i(left_b), .sig_detect_i(sig_detect_i), .test_pat_i(test_pat_i),
      .pwr_good_i(pwr_good_i), .nv_valid_i(nv_valid), .nv_src_i(nv_src),
      .nv_gain_i(nv_gain), .src_sel_o(src_sel), .gain_o(gain), .src_lamp_o(src_lamp),
      .gain_green_o(gain_green), .gain_red_o(gain_red), .in_lamp_o(in_lamp),
      .pwr_lamp_o(pwr_lamp), .editing_o(editing), .nv_wr_o(nv_wr),
      .nv_wr_src_o(nv_wr_src), .nv_wr_gain_o(nv_wr_gain));

   fpc_op_model i_fpc_op_model (
      .clk_i(clk_i), .nv_wr_i(nv_wr), .nv_wr_src_i(nv_wr_src), .nv_wr_gain_i(nv_wr_gain),
      .sec_btn_o(sec_b), .right_btn_o(right_b), .left_btn_o(left_b),
      .nv_valid_o(nv_valid), .nv_src_o(nv_src), .nv_gain_o(nv_gain));

   // clock, 100 ns period
   always #50 clk_i = ~clk_i;

   // cycle count, commit pulse count and hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (nv_wr === 1'b1) nwr++;
      if (cyc == LIMIT) begin
         miscompares++;
         $display("CHECK FAILED t=%0t timeout", $time);
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask

   // wait for the commit pulse, bounded, and check what it carries
   task automatic commit_wait(input logic [1:0] es, input logic [7:0] eg);
      wt = 0;
      // poll between edges so the one-cycle pulse is seen settled
      while (nv_wr !== 1'b1 && wt < COMMIT + 100) begin
         @(negedge clk_i);
         wt++;
      end
      `CHK(nv_wr, 1'b1)
      `CHK(wt > COMMIT - 20, 1'b1)
      `CHK(nv_wr_src, es)
      `CHK(nv_wr_gain, eg)
      repeat (4) @(posedge clk_i);
   endtask

   // dark samples of one lamp over a full blink period
   task automatic dark_cnt(input bit gain_lamp, output int n);
      n = 0;
      repeat (2 * BLINK) begin
         @(negedge clk_i);
         if (gain_lamp ? ({gain_green, gain_red} == 2'h0) : (src_lamp == 4'h0)) n++;
      end
   endtask

   initial begin
      rst_i        <= 1'b1;
      sig_detect_i <= 1'b0;
      test_pat_i   <= 1'b0;
      pwr_good_i   <= 1'b1;
      do_reset();
      // store not readable yet: reset values hold
      `CHK({src_sel, gain}, {2'h0, 8'h64})
      i_fpc_op_model.store_ready();
      // stored values applied after power-up, lamps steady
      `CHK(src_sel, 2'h2)
      `CHK(gain, 8'h5A)
      `CHK(src_lamp, 4'h4)
      `CHK({gain_green, gain_red}, 2'h1)
      `CHK(pwr_lamp, 1'b1)
      `CHK(editing, 1'b0)
      // right arrow outside a section changes nothing
      i_fpc_op_model.press(1);
      `CHK({src_sel, gain}, {2'h2, 8'h5A})
      i_fpc_op_model.press(0);
      `CHK(editing, 1'b1)
      // source steps up and wraps past the last format
      for (int i = 1; i <= 2; i++) begin
         i_fpc_op_model.press(1);
         `CHK(src_sel, 2'((2 + i) % 4))
      end
      // edited source lamp blinks: dark half of each period
      dark_cnt(1'b0, wt);
      `CHK(wt, BLINK)
      i_fpc_op_model.press(0);
      i_fpc_op_model.press(1);
      `CHK(gain, 8'h5B)
      i_fpc_op_model.press(2);
      i_fpc_op_model.press(2);
      `CHK(gain, 8'h59)
      dark_cnt(1'b1, wt);
      `CHK(wt, BLINK)
      // chord returns to nominal without an extra step
      i_fpc_op_model.press(3);
      `CHK(gain, 8'h64)
      `CHK(nwr, 0)
      commit_wait(2'h0, 8'h64);
      `CHK(nwr, 1)
      `CHK(editing, 1'b0)
      `CHK({gain_green, gain_red}, 2'h2)
      `CHK(src_lamp, 4'h1)
      // gain limits at both ends
      i_fpc_op_model.press(0);
      i_fpc_op_model.press(0);
      repeat (52) i_fpc_op_model.press(2);
      `CHK(gain, 8'h32)
      repeat (101) i_fpc_op_model.press(1);
      `CHK(gain, 8'h96)
      // only two sections: the next press is back in source
      i_fpc_op_model.press(0);
      i_fpc_op_model.press(1);
      `CHK({src_sel, gain}, {2'h1, 8'h96})
      // reset with edits pending keeps the last committed values
      do_reset();
      `CHK({src_sel, gain}, {2'h0, 8'h64})
      `CHK(nwr, 1)
      // input lamp against detect and test pattern
      for (int i = 0; i < 4; i++) begin
         sig_detect_i <= i[0];
         test_pat_i   <= i[1];
         repeat (8) @(posedge clk_i);
         `CHK(in_lamp, 1'(i == 1))
      end
      pwr_good_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK(pwr_lamp, 1'b0)
      pwr_good_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK(pwr_lamp, 1'b1)
      wrap_up();
   end
endmodule
`default_nettype wire
